// *** src/edge_line_event_controller.v ***
// edge line event controller: 24 edge lines, masks, pending flags, avalon slave
// Overview of operation
// - twenty-four edge lines, each raising an interrupt or event request on edge
// - per line, software enables rising, falling or both edges as trigger
// - per-line masks stop forwarding of that line only
// - detected edge sets a readable pending flag that holds until cleared
// - edges compared between consecutive samples, single-sample pulses still caught
// - sixteen lines each watch one of 168 gpio pins via selector
`timescale 1ns/10ps
`include "edge_line_event_controller_defines.vh"

module edge_line_event_controller (
  // clock and reset
  input wire clk,
  input wire rst,
  // avalon-mm slave
  input wire [`ADDR_WIDTH-1:0] address,
  input wire read,
  input wire write,
  input wire [`DATA_WIDTH-1:0] writedata,
  input wire [3:0] byteenable,
  output reg [`DATA_WIDTH-1:0] readdata,
  output reg waitrequest,
  // watched inputs
  input wire [`GPIO_COUNT-1:0] gpio_in,
  input wire [`INT_LINE_COUNT-1:0] internal_line_in,
  // requests
  output reg irq,
  output reg [`LINE_COUNT-1:0] line_irq,
  output reg [`LINE_COUNT-1:0] line_event
);

  // control and status
  reg [`LINE_COUNT-1:0] rise_en_reg;
  reg [`LINE_COUNT-1:0] fall_en_reg;
  reg [`LINE_COUNT-1:0] int_mask_reg;
  reg [`LINE_COUNT-1:0] evt_mask_reg;
  reg [`LINE_COUNT-1:0] rise_en_next;
  reg [`LINE_COUNT-1:0] fall_en_next;
  reg [`LINE_COUNT-1:0] int_mask_next;
  reg [`LINE_COUNT-1:0] evt_mask_next;
  reg [`LINE_COUNT-1:0] pending_reg;
  reg [`LINE_COUNT-1:0] pending_next;
  reg [`LINE_COUNT-1:0] level_reg;
  reg [`LINE_COUNT-1:0] prev_reg;
  reg prev_valid_reg;

  // bus state
  reg [1:0] phase_reg;
  reg [1:0] phase_next;
  reg [`DATA_WIDTH-1:0] read_mux;
  reg [`LINE_COUNT-1:0] be_mask;
  reg [`DATA_WIDTH-1:0] readdata_next;
  reg waitrequest_next;

  // request next values
  reg [`LINE_COUNT-1:0] line_irq_next;
  reg [`LINE_COUNT-1:0] line_event_next;
  reg irq_next;

  wire req;
  wire access;
  wire wr_access;
  wire sel_hit;
  wire [`SEL_ADDR_WIDTH-1:0] sel_index;
  wire [`SEL_WIDTH-1:0] sel_rd_data;
  wire [`PIN_LINE_COUNT*`SEL_WIDTH-1:0] sel_flat;
  wire [`LINE_COUNT-1:0] line_now;
  wire [`LINE_COUNT-1:0] edge_rise;
  wire [`LINE_COUNT-1:0] edge_fall;
  wire [`LINE_COUNT-1:0] edge_hit;
  wire [`LINE_COUNT-1:0] clear_req;
  wire sel_wr_en;
  // decoded write field and pending word hit
  wire [`LINE_COUNT-1:0] wr_field;
  wire pending_hit;

  assign req = read | write;
  // access completes at the edge where waitrequest is seen low
  assign access = req && (phase_reg == `PH_DONE);
  assign wr_access = write && access;
  assign sel_hit = (address >= `OFS_SEL_BASE) && (address <= `OFS_SEL_LAST)
    && (address[1:0] == 2'h0);
  assign sel_index = address[`SEL_ADDR_WIDTH+1:2];
  assign sel_wr_en = wr_access && sel_hit && byteenable[0];
  // write data cut to the fields and gated by byte lane
  assign wr_field = writedata[`LINE_COUNT-1:0] & be_mask;
  assign pending_hit = (address == `OFS_PENDING);

  // byte lanes applied to the 24-bit fields
  always @* begin
    be_mask = {{8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  end

  // pin selector table
  // reads and writes share one word index
  line_select_table u_table (
    .clk(clk),
    .rst(rst),
    .wr_en(sel_wr_en),
    .wr_addr(sel_index),
    .wr_data(writedata[`SEL_WIDTH-1:0]),
    .rd_addr(sel_index),
    .rd_data(sel_rd_data),
    .sel_flat(sel_flat)
  );

  // line sources: sixteen selected pins, then the internal lines
  genvar g;
  generate
    for (g = 0; g < `LINE_COUNT; g = g + 1) begin : gen_line
      if (g < `PIN_LINE_COUNT) begin : gen_pin
        wire [`SEL_WIDTH-1:0] pick;
        assign pick = sel_flat[g*`SEL_WIDTH +: `SEL_WIDTH];
        // out-of-range selection watches a constant low
        assign line_now[g] = (pick < `GPIO_COUNT) ? gpio_in[pick] : 1'b0;
      end else begin : gen_int
        assign line_now[g] = internal_line_in[g-`PIN_LINE_COUNT];
      end
      // raw change against the previous sample
      wire went_high;
      wire went_low;
      assign went_high = prev_valid_reg && line_now[g] && !prev_reg[g];
      assign went_low = prev_valid_reg && !line_now[g] && prev_reg[g];
      assign edge_rise[g] = went_high && rise_en_reg[g];
      assign edge_fall[g] = went_low && fall_en_reg[g];
      assign edge_hit[g] = edge_rise[g] | edge_fall[g];
    end
  endgenerate

  // previous sample of every line
  always @(posedge clk) begin
    if (rst) begin
      prev_reg <= {`LINE_COUNT{1'b0}};
      prev_valid_reg <= 1'b0;
    end else begin
      // one sample apart, so a one-cycle pulse gives both edges
      prev_reg <= line_now;
      // the reset value of prev_reg is never judged as an edge
      prev_valid_reg <= 1'b1;
    end
  end

  // current line levels for software
  always @(posedge clk) begin
    if (rst) begin
      level_reg <= {`LINE_COUNT{1'b0}};
    end else begin
      level_reg <= line_now;
    end
  end

  // pending flags: a new edge wins over a clear in the same cycle
  assign clear_req = (wr_access && pending_hit) ? wr_field : {`LINE_COUNT{1'b0}};

  always @* begin
    pending_next = (pending_reg & ~clear_req) | edge_hit;
  end

  always @(posedge clk) begin
    if (rst) begin
      pending_reg <= `RST_PENDING;
    end else begin
      // flags hold until cleared or reset
      pending_reg <= pending_next;
    end
  end

  // configuration next values, only the addressed word changes
  always @* begin
    rise_en_next = rise_en_reg;
    fall_en_next = fall_en_reg;
    int_mask_next = int_mask_reg;
    evt_mask_next = evt_mask_reg;
    if (wr_access) begin
      case (address)
        `OFS_RISE_EN: begin
          rise_en_next = (rise_en_reg & ~be_mask) | wr_field;
        end
        `OFS_FALL_EN: begin
          fall_en_next = (fall_en_reg & ~be_mask) | wr_field;
        end
        `OFS_INT_MASK: begin
          int_mask_next = (int_mask_reg & ~be_mask) | wr_field;
        end
        `OFS_EVT_MASK: begin
          evt_mask_next = (evt_mask_reg & ~be_mask) | wr_field;
        end
        default: begin
          // other words leave every field alone
          rise_en_next = rise_en_reg;
        end
      endcase
    end
  end

  // configuration registers
  always @(posedge clk) begin
    if (rst) begin
      rise_en_reg <= `RST_RISE_EN;
      fall_en_reg <= `RST_FALL_EN;
      int_mask_reg <= `RST_INT_MASK;
      evt_mask_reg <= `RST_EVT_MASK;
    end else begin
      rise_en_reg <= rise_en_next;
      fall_en_reg <= fall_en_next;
      int_mask_reg <= int_mask_next;
      evt_mask_reg <= evt_mask_next;
    end
  end

  // requests: a mask written this cycle already applies
  always @* begin
    // a masked line forwards nothing, others are untouched
    line_irq_next = pending_next & int_mask_next;
    line_event_next = edge_hit & evt_mask_next;
    irq_next = |line_irq_next;
  end

  // requests toward the consumers
  always @(posedge clk) begin
    if (rst) begin
      line_irq <= {`LINE_COUNT{1'b0}};
      line_event <= {`LINE_COUNT{1'b0}};
      irq <= 1'b0;
    end else begin
      // all from one next value, so irq never lags line_irq
      line_irq <= line_irq_next;
      line_event <= line_event_next;
      irq <= irq_next;
    end
  end

  // read data selection
  always @* begin
    read_mux = {`DATA_WIDTH{1'b0}};
    if (sel_hit) begin
      read_mux[`SEL_WIDTH-1:0] = sel_rd_data;
    end else begin
      case (address)
        `OFS_RISE_EN: read_mux[`LINE_COUNT-1:0] = rise_en_reg;
        `OFS_FALL_EN: read_mux[`LINE_COUNT-1:0] = fall_en_reg;
        `OFS_INT_MASK: read_mux[`LINE_COUNT-1:0] = int_mask_reg;
        `OFS_EVT_MASK: read_mux[`LINE_COUNT-1:0] = evt_mask_reg;
        `OFS_PENDING: read_mux[`LINE_COUNT-1:0] = pending_reg;
        `OFS_LEVEL: read_mux[`LINE_COUNT-1:0] = level_reg;
        default: read_mux = {`DATA_WIDTH{1'b0}};
      endcase
    end
  end

  // bus phases: request seen, table read settles, answer
  always @* begin
    phase_next = `PH_IDLE;
    case (phase_reg)
      `PH_IDLE: begin
        // a request starts a fresh access
        if (req) begin
          phase_next = `PH_FETCH;
        end
      end
      `PH_FETCH: begin
        // table read data stand in this cycle
        if (req) begin
          phase_next = `PH_DONE;
        end
      end
      `PH_DONE: begin
        // one answer cycle, then idle again
        phase_next = `PH_IDLE;
      end
      default: begin
        phase_next = `PH_IDLE;
      end
    endcase
  end

  // answer next values
  always @* begin
    // low for exactly the cycle the request completes
    waitrequest_next = !(phase_next == `PH_DONE);
    readdata_next = readdata;
    // selector reads need the table's registered data first
    if (read && (phase_reg == `PH_FETCH)) begin
      readdata_next = read_mux;
    end
  end

  // answer registers
  always @(posedge clk) begin
    if (rst) begin
      phase_reg <= `PH_IDLE;
      waitrequest <= 1'b1;
      readdata <= {`DATA_WIDTH{1'b0}};
    end else begin
      phase_reg <= phase_next;
      waitrequest <= waitrequest_next;
      readdata <= readdata_next;
    end
  end

endmodule // edge_line_event_controller

// *** src/edge_line_event_controller_defines.vh ***
// constants for the edge line event controller
`ifndef EDGE_LINE_EVENT_CONTROLLER_DEFINES_VH
`define EDGE_LINE_EVENT_CONTROLLER_DEFINES_VH

// geometry
`define LINE_COUNT 24
`define PIN_LINE_COUNT 16
`define INT_LINE_COUNT 8
`define GPIO_COUNT 168
`define SEL_WIDTH 8
`define SEL_ADDR_WIDTH 4

// avalon slave
`define ADDR_WIDTH 8
`define DATA_WIDTH 32

// register byte offsets
`define OFS_RISE_EN 8'h00
`define OFS_FALL_EN 8'h04
`define OFS_INT_MASK 8'h08
`define OFS_EVT_MASK 8'h0c
`define OFS_PENDING 8'h10
`define OFS_LEVEL 8'h14
`define OFS_SEL_BASE 8'h40
`define OFS_SEL_LAST 8'h7c

// reset values
`define RST_RISE_EN 24'h000000
`define RST_FALL_EN 24'h000000
`define RST_INT_MASK 24'h000000
`define RST_EVT_MASK 24'h000000
`define RST_PENDING 24'h000000
`define RST_SEL 8'h00

// bus answer phases
`define PH_IDLE 2'h0
`define PH_FETCH 2'h1
`define PH_DONE 2'h2

`endif

// *** src/line_select_table.v ***
// table of gpio pin selections for the pin-fed lines
`timescale 1ns/10ps
`include "edge_line_event_controller_defines.vh"

module line_select_table (
  // clock and reset
  input wire clk,
  input wire rst,
  // write port
  input wire wr_en,
  input wire [`SEL_ADDR_WIDTH-1:0] wr_addr,
  input wire [`SEL_WIDTH-1:0] wr_data,
  // registered read port
  input wire [`SEL_ADDR_WIDTH-1:0] rd_addr,
  output reg [`SEL_WIDTH-1:0] rd_data,
  // all entries at once for the pin selectors
  output wire [`PIN_LINE_COUNT*`SEL_WIDTH-1:0] sel_flat
);

  reg [`SEL_WIDTH-1:0] entry_reg [0:`PIN_LINE_COUNT-1];

  genvar g;
  generate
    for (g = 0; g < `PIN_LINE_COUNT; g = g + 1) begin : gen_entry
      always @(posedge clk) begin
        if (rst) begin
          entry_reg[g] <= `RST_SEL;
        end else if (wr_en && (wr_addr == g)) begin
          entry_reg[g] <= wr_data;
        end
      end
      assign sel_flat[g*`SEL_WIDTH +: `SEL_WIDTH] = entry_reg[g];
    end
  endgenerate

  always @(posedge clk) begin
    if (rst) begin
      rd_data <= `RST_SEL;
    end else begin
      rd_data <= entry_reg[rd_addr];
    end
  end

endmodule // line_select_table

// *** bench/edge_line_event_controller_checker.sv ***
// port assertions for the edge line event controller
`timescale 1ns/10ps
`include "edge_line_event_controller_defines.vh"
module edge_line_event_controller_checker (
  // clock and reset
  input wire clk,
  input wire rst,
  // bus and requests
  input wire read,
  input wire write,
  input wire [`DATA_WIDTH-1:0] readdata,
  input wire waitrequest,
  input wire irq,
  input wire [`LINE_COUNT-1:0] line_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_answer;
    waitrequest [*2] ##1 !waitrequest;
  endsequence
  a_wait_two: assert property ($rose(read || write) |-> s_answer)
    else $error("bad wait");
  a_wait_one: assert property (!waitrequest |=> waitrequest)
    else $error("long answer");
  a_wait_idle: assert property (!(read || write) |-> waitrequest)
    else $error("idle answer");
  a_irq_level: assert property (irq == (|line_irq))
    else $error("irq level");
  a_irq_fall: assert property ($fell(irq) |-> $past(write && !waitrequest))
    else $error("irq fell");
  a_line_fall: assert property (|($past(line_irq) & ~line_irq) |->
    $past(write && !waitrequest)) else $error("line fell");
  a_rsvd_zero: assert property (read && !waitrequest |-> readdata[31:24] == 8'h00)
    else $error("reserved bits");
  a_rdata_hold: assert property ($changed(readdata) |-> read && !waitrequest)
    else $error("readdata moved");
endmodule // edge_line_event_controller_checker
bind edge_line_event_controller edge_line_event_controller_checker chk (.clk(clk), .rst(rst),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
  .line_irq(line_irq));

// *** bench/line_source.sv ***
// pin and internal line source for the edge line event controller
`timescale 1ns/10ps
`include "edge_line_event_controller_defines.vh"
module line_source (
  // clock
  input wire clk,
  // pulse request, targets 168 and up are internal lines
  input wire go,
  input wire [7:0] target,
  // driven lines
  output reg [`GPIO_COUNT-1:0] gpio_in = 0,
  output reg [`INT_LINE_COUNT-1:0] internal_line_in = 0
);
  always @(posedge clk) begin
    gpio_in <= 0;
    internal_line_in <= 8'h00;
    if (go && target < 8'd168) gpio_in[target] <= 1'b1;
    if (go && target >= 8'd168) internal_line_in[target - 8'd168] <= 1'b1;
  end
endmodule // line_source

// *** bench/edge_line_event_controller_tb.sv ***
// self-checking bench for the edge line event controller
`timescale 1ns/10ps
module edge_line_event_controller_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] address = 8'h00;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0;
  reg go = 1'b0;
  reg [7:0] target = 8'h00;
  wire [31:0] readdata;
  wire waitrequest, irq;
  wire [23:0] line_irq, line_event;
  wire [167:0] gpio_in;
  wire [7:0] internal_line_in;
  reg [31:0] rd;
  integer fail_count = 0;
  integer total_checks = 0;
  integer ev_count = 0;
  integer i;
  always #5 clk = ~clk;
  always @(negedge clk) if (line_event[16] === 1'b1) ev_count = ev_count + 1;
  edge_line_event_controller DUT (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
    .waitrequest(waitrequest), .gpio_in(gpio_in), .internal_line_in(internal_line_in),
    .irq(irq), .line_irq(line_irq), .line_event(line_event));
  line_source pins (.clk(clk), .go(go), .target(target), .gpio_in(gpio_in),
    .internal_line_in(internal_line_in));
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task bus(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      check("readdata", rd, exp);
    end
  endtask
  task pulse(input [7:0] t);
    begin
      @(posedge clk);
      go <= 1'b1;
      target <= t;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #50000;
    fail_count = fail_count + 1;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i = i + 1) rd_chk(i * 4, 32'h0);
    rd_chk(8'h20, 32'h0);
    $display("test reset done");
    bus(1'b1, 8'h40, 32'd5);
    bus(1'b1, 8'h44, 32'd167);
    bus(1'b1, 8'h00, 32'h010001);
    bus(1'b1, 8'h04, 32'h010002);
    bus(1'b1, 8'h08, 32'h010003);
    bus(1'b1, 8'h0c, 32'h010000);
    rd_chk(8'h44, 32'd167);
    pulse(8'd5);
    rd_chk(8'h10, 32'h1);
    pulse(8'd167);
    rd_chk(8'h10, 32'h3);
    @(negedge clk);
    check("irq", irq, 32'h1);
    bus(1'b1, 8'h10, 32'h0);
    rd_chk(8'h10, 32'h3);
    bus(1'b1, 8'h10, 32'h1);
    rd_chk(8'h10, 32'h2);
    $display("test edges done");
    bus(1'b1, 8'h08, 32'h010001);
    @(negedge clk);
    check("line_irq", line_irq, 32'h0);
    check("irq", irq, 32'h0);
    pulse(8'd168);
    rd_chk(8'h10, 32'h010002);
    @(negedge clk);
    check("events", ev_count, 32'd2);
    check("line_irq", line_irq, 32'h010000);
    bus(1'b1, 8'h10, 32'hffffff);
    rd_chk(8'h10, 32'h0);
    pulse(8'd5);
    rd_chk(8'h10, 32'h1);
    $display("test masks done");
    tally_and_finish;
  end
endmodule // edge_line_event_controller_tb
